/* File: hw/hbc_pkg.sv */
/*
 * package for the half-bridge configuration register bank: offsets,
 * field positions, reset values, write masks, timing figures and the
 * field carrier. assumes a 250 MHz device clock.
 */
package hbc_pkg;

   // -------------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] LOAD_DIAG_TRIP_OFS  = 8'h0b;
   localparam logic [7:0] REG_SLEW_OFS        = 8'h0c;
   localparam logic [7:0] OC_PIN_COMBINE_OFS  = 8'h0d;

   // -------------------------------------------------------------------
   // reset values and writable-bit masks
   // -------------------------------------------------------------------
   localparam logic [7:0] LOAD_DIAG_TRIP_RST  = 8'h00;
   localparam logic [7:0] REG_SLEW_RST        = 8'h40;
   localparam logic [7:0] OC_PIN_COMBINE_RST  = 8'h04;
   localparam logic [7:0] LOAD_DIAG_TRIP_WMSK = 8'he7;
   localparam logic [7:0] REG_SLEW_WMSK       = 8'hdf;
   localparam logic [7:0] OC_PIN_COMBINE_WMSK = 8'hdf;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int LDT_SPARE_BIT       = 7;
   localparam int LDT_LOAD_TYPE_LSB   = 5;
   localparam int LDT_TRIP_LEVEL_LSB  = 0;
   localparam int RS_OFF_TIME_LSB     = 6;
   localparam int RS_SLEW_LSB         = 2;
   localparam int RS_SPARE_LSB        = 0;
   localparam int OC_FILTER_LSB       = 6;
   localparam int OC_THRESH_LSB       = 3;
   localparam int OC_DRIVER_OFF_COMBINE_SELECT_BIT   = 2;
   localparam int OC_SPARE_BIT        = 1;
   localparam int OC_BRIDGE_SEL_BIT   = 0;

   // -------------------------------------------------------------------
   // lock codes
   // -------------------------------------------------------------------
   localparam logic [1:0] PIN_OVERRIDE_UNLOCK = 2'b10;
   localparam logic [1:0] CFG_WRITE_LOCK      = 2'b10;

   // -------------------------------------------------------------------
   // timing figures
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_PS       = 4000;
   localparam int OFF_TIME_0_NS       = 20000;
   localparam int OFF_TIME_1_NS       = 30000;
   localparam int OFF_TIME_2_NS       = 40000;
   localparam int OFF_TIME_3_NS       = 50000;
   localparam int OC_FILT_0_NS        = 6000;
   localparam int OC_FILT_1_NS        = 3000;
   localparam int OC_FILT_2_NS        = 1500;
   localparam int OC_FILT_3_NS        = 200;
   localparam int OFF_TIME_0_CYC      = OFF_TIME_0_NS * 1000 / CLK_PERIOD_PS;
   localparam int OFF_TIME_1_CYC      = OFF_TIME_1_NS * 1000 / CLK_PERIOD_PS;
   localparam int OFF_TIME_2_CYC      = OFF_TIME_2_NS * 1000 / CLK_PERIOD_PS;
   localparam int OFF_TIME_3_CYC      = OFF_TIME_3_NS * 1000 / CLK_PERIOD_PS;
   localparam int OC_FILT_0_CYC       = OC_FILT_0_NS * 1000 / CLK_PERIOD_PS;
   localparam int OC_FILT_1_CYC       = OC_FILT_1_NS * 1000 / CLK_PERIOD_PS;
   localparam int OC_FILT_2_CYC       = OC_FILT_2_NS * 1000 / CLK_PERIOD_PS;
   localparam int OC_FILT_3_CYC       = OC_FILT_3_NS * 1000 / CLK_PERIOD_PS;

   // -------------------------------------------------------------------
   // threshold percentages
   // -------------------------------------------------------------------
   localparam logic [6:0] THRESH_FULL_PCT  = 7'h64;
   localparam logic [6:0] THRESH_3Q_PCT    = 7'h4b;
   localparam logic [6:0] THRESH_HALF_PCT  = 7'h32;

   // -------------------------------------------------------------------
   // field carrier
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] load_type_select;
      logic [2:0] trip_level_select;
      logic [1:0] regulation_off_time;
      logic [2:0] slew_rate_select;
      logic [1:0] overcurrent_filter_select;
      logic [1:0] overcurrent_threshold_select;
      logic       driver_off_combine_select;
      logic       bridge_combine_select;
   } hbc_cfg_t;

endpackage : hbc_pkg

/* File: hw/hbc_pin_combine.sv */
/*
 * one pin-with-register-copy combiner, registered output.
 * assumes pin and register copy are synchronous to the device clock.
 */
module hbc_pin_combine (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_pin,
   input  wire logic i_soft,
   input  wire logic i_override_en,
   input  wire logic i_and_sel,
   input  wire logic i_rst_val,
   output logic      o_level
);

   logic combined_nxt;

   // -------------------------------------------------------------------
   // combine
   // -------------------------------------------------------------------
   always_comb
   begin
      if (!i_override_en)
         combined_nxt = i_pin;
      else if (i_and_sel)
         combined_nxt = i_pin & i_soft;
      else
         combined_nxt = i_pin | i_soft;
   end

   // reset value is fixed at zero here; i_rst_val tied at the parent is not used
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_level <= 1'b0;
      else
         o_level <= combined_nxt;
   end

endmodule : hbc_pin_combine

/* File: hw/hbc_config_regs.sv */
/*
 * three configuration registers of a half-bridge driver, with write
 * lock, pin override combining and decoded timing outputs.
 * assumes the serial front end delivers decoded byte accesses, and the
 * command register (lock codes, soft pin copies) lives outside.
 */
module hbc_config_regs #(
   parameter int OFF_TIME_0_CYCLES = hbc_pkg::OFF_TIME_0_CYC,
   parameter int OFF_TIME_1_CYCLES = hbc_pkg::OFF_TIME_1_CYC,
   parameter int OFF_TIME_2_CYCLES = hbc_pkg::OFF_TIME_2_CYC,
   parameter int OFF_TIME_3_CYCLES = hbc_pkg::OFF_TIME_3_CYC
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_wr_en,
   input  wire logic       i_rd_en,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic [1:0] i_cfg_lock_code,
   input  wire logic [1:0] i_pin_lock_code,
   input  wire logic       i_soft_bridge_command,
   input  wire logic       i_soft_driver_off,
   input  wire logic       i_bridge_command_pin,
   input  wire logic       i_driver_off_pin,
   output logic [7:0]      o_rd_data,
   output logic            o_rd_valid,
   output logic            o_rd_hit,
   output logic            o_wr_refused,
   output hbc_pkg::hbc_cfg_t o_cfg,
   output logic [13:0]     o_off_time_cycles,
   output logic [10:0]     o_oc_filter_cycles,
   output logic [6:0]      o_oc_threshold_pct,
   output logic            o_bridge_command,
   output logic            o_driver_off
);

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   logic [7:0]  load_diag_trip_r;
   logic [7:0]  regulation_slew_r;
   logic [7:0]  oc_pin_combine_r;
   logic [7:0]  rd_data_nxt;
   logic        rd_hit_nxt;
   logic        cfg_locked;
   logic        override_en;
   logic        wr_a_hit;
   logic        wr_b_hit;
   logic        wr_c_hit;
   logic        wr_any_hit;
   logic [13:0] off_time_nxt;
   logic [10:0] filter_nxt;
   logic [6:0]  thresh_nxt;
   logic        driver_off_lvl;
   logic        bridge_cmd_lvl;

   // -------------------------------------------------------------------
   // lock decode
   // -------------------------------------------------------------------
   // lock codes come from outside and take effect in the same cycle
   assign cfg_locked  = (i_cfg_lock_code == hbc_pkg::CFG_WRITE_LOCK);
   assign override_en =
      (i_pin_lock_code == hbc_pkg::PIN_OVERRIDE_UNLOCK);

   // -------------------------------------------------------------------
   // write decode
   // -------------------------------------------------------------------
   assign wr_a_hit   = (i_addr == hbc_pkg::LOAD_DIAG_TRIP_OFS);
   assign wr_b_hit   = (i_addr == hbc_pkg::REG_SLEW_OFS);
   assign wr_c_hit   = (i_addr == hbc_pkg::OC_PIN_COMBINE_OFS);
   assign wr_any_hit = wr_a_hit | wr_b_hit | wr_c_hit;

   // -------------------------------------------------------------------
   // load diagnostic / trip level register
   // -------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         load_diag_trip_r <= hbc_pkg::LOAD_DIAG_TRIP_RST;
      else if (i_wr_en && wr_a_hit && !cfg_locked)
         // masked bits stay zero so they always read back zero
         load_diag_trip_r <= i_wr_data &
                             hbc_pkg::LOAD_DIAG_TRIP_WMSK;
   end

   // -------------------------------------------------------------------
   // regulation off time / slew register
   // -------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         regulation_slew_r <= hbc_pkg::REG_SLEW_RST;
      else if (i_wr_en && wr_b_hit && !cfg_locked)
         regulation_slew_r <= i_wr_data &
                              hbc_pkg::REG_SLEW_WMSK;
   end

   // -------------------------------------------------------------------
   // over-current / pin combine register
   // -------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         oc_pin_combine_r <= hbc_pkg::OC_PIN_COMBINE_RST;
      else if (i_wr_en && wr_c_hit && !cfg_locked)
         oc_pin_combine_r <= i_wr_data &
                             hbc_pkg::OC_PIN_COMBINE_WMSK;
   end

   // -------------------------------------------------------------------
   // write refusal flag
   // -------------------------------------------------------------------
   // one-cycle pulse so firmware debug can see a dropped write
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_wr_refused <= 1'b0;
      else
         o_wr_refused <= i_wr_en & wr_any_hit & cfg_locked;
   end

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   always_comb
   begin
      rd_data_nxt = 8'h00;
      rd_hit_nxt  = 1'b1;
      case (i_addr)
         hbc_pkg::LOAD_DIAG_TRIP_OFS: rd_data_nxt = load_diag_trip_r;
         hbc_pkg::REG_SLEW_OFS:       rd_data_nxt = regulation_slew_r;
         hbc_pkg::OC_PIN_COMBINE_OFS: rd_data_nxt = oc_pin_combine_r;
         default:                     rd_hit_nxt  = 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rd_data  <= 8'h00;
         o_rd_valid <= 1'b0;
         o_rd_hit   <= 1'b0;
      end
      else
      begin
         o_rd_valid <= i_rd_en;
         if (i_rd_en)
         begin
            o_rd_data <= rd_data_nxt;
            o_rd_hit  <= rd_hit_nxt;
         end
      end
   end

   // -------------------------------------------------------------------
   // field outputs
   // -------------------------------------------------------------------
   // spare bits reach only the read path, never o_cfg
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         // reset image follows the register reset values, so no field
         // shows a wrong code in the first cycle after release
         o_cfg.load_type_select <=
            hbc_pkg::LOAD_DIAG_TRIP_RST[hbc_pkg::LDT_LOAD_TYPE_LSB +: 2];
         o_cfg.trip_level_select <=
            hbc_pkg::LOAD_DIAG_TRIP_RST[hbc_pkg::LDT_TRIP_LEVEL_LSB +: 3];
         o_cfg.regulation_off_time <=
            hbc_pkg::REG_SLEW_RST[hbc_pkg::RS_OFF_TIME_LSB +: 2];
         o_cfg.slew_rate_select <=
            hbc_pkg::REG_SLEW_RST[hbc_pkg::RS_SLEW_LSB +: 3];
         o_cfg.overcurrent_filter_select <=
            hbc_pkg::OC_PIN_COMBINE_RST[hbc_pkg::OC_FILTER_LSB +: 2];
         o_cfg.overcurrent_threshold_select <=
            hbc_pkg::OC_PIN_COMBINE_RST[hbc_pkg::OC_THRESH_LSB +: 2];
         o_cfg.driver_off_combine_select <=
            hbc_pkg::OC_PIN_COMBINE_RST[hbc_pkg::OC_DRIVER_OFF_COMBINE_SELECT_BIT];
         o_cfg.bridge_combine_select <=
            hbc_pkg::OC_PIN_COMBINE_RST[hbc_pkg::OC_BRIDGE_SEL_BIT];
      end
      else
      begin
         o_cfg.load_type_select <=
            load_diag_trip_r[hbc_pkg::LDT_LOAD_TYPE_LSB +: 2];
         o_cfg.trip_level_select <=
            load_diag_trip_r[hbc_pkg::LDT_TRIP_LEVEL_LSB +: 3];
         o_cfg.regulation_off_time <=
            regulation_slew_r[hbc_pkg::RS_OFF_TIME_LSB +: 2];
         o_cfg.slew_rate_select <=
            regulation_slew_r[hbc_pkg::RS_SLEW_LSB +: 3];
         o_cfg.overcurrent_filter_select <=
            oc_pin_combine_r[hbc_pkg::OC_FILTER_LSB +: 2];
         o_cfg.overcurrent_threshold_select <=
            oc_pin_combine_r[hbc_pkg::OC_THRESH_LSB +: 2];
         o_cfg.driver_off_combine_select <=
            oc_pin_combine_r[hbc_pkg::OC_DRIVER_OFF_COMBINE_SELECT_BIT];
         o_cfg.bridge_combine_select <=
            oc_pin_combine_r[hbc_pkg::OC_BRIDGE_SEL_BIT];
      end
   end

   // -------------------------------------------------------------------
   // off-time decode
   // -------------------------------------------------------------------
   always_comb
   begin
      case (regulation_slew_r[hbc_pkg::RS_OFF_TIME_LSB +: 2])
         2'h0:    off_time_nxt = 14'(OFF_TIME_0_CYCLES);
         2'h1:    off_time_nxt = 14'(OFF_TIME_1_CYCLES);
         2'h2:    off_time_nxt = 14'(OFF_TIME_2_CYCLES);
         default: off_time_nxt = 14'(OFF_TIME_3_CYCLES);
      endcase
   end

   // -------------------------------------------------------------------
   // over-current filter and threshold decode
   // -------------------------------------------------------------------
   // shortest filter is nominal only; 50 cycles is its best fixed image
   always_comb
   begin
      case (oc_pin_combine_r[hbc_pkg::OC_FILTER_LSB +: 2])
         2'h0:    filter_nxt = 11'(hbc_pkg::OC_FILT_0_CYC);
         2'h1:    filter_nxt = 11'(hbc_pkg::OC_FILT_1_CYC);
         2'h2:    filter_nxt = 11'(hbc_pkg::OC_FILT_2_CYC);
         default: filter_nxt = 11'(hbc_pkg::OC_FILT_3_CYC);
      endcase
   end

   always_comb
   begin
      case (oc_pin_combine_r[hbc_pkg::OC_THRESH_LSB +: 2])
         2'h0:    thresh_nxt = hbc_pkg::THRESH_FULL_PCT;
         2'h2:    thresh_nxt = hbc_pkg::THRESH_3Q_PCT;
         default: thresh_nxt = hbc_pkg::THRESH_HALF_PCT;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_off_time_cycles  <= 14'(OFF_TIME_1_CYCLES);
         o_oc_filter_cycles <= 11'(hbc_pkg::OC_FILT_0_CYC);
         o_oc_threshold_pct <= hbc_pkg::THRESH_FULL_PCT;
      end
      else
      begin
         o_off_time_cycles  <= off_time_nxt;
         o_oc_filter_cycles <= filter_nxt;
         o_oc_threshold_pct <= thresh_nxt;
      end
   end

   // -------------------------------------------------------------------
   // pin combining
   // -------------------------------------------------------------------
   // when locked the pins pass straight; soft copies are ignored
   hbc_pin_combine u_drv_off (
      .i_ref_clk     (i_ref_clk),
      .i_rst_n       (i_rst_n),
      .i_pin         (i_driver_off_pin),
      .i_soft        (i_soft_driver_off),
      .i_override_en (override_en),
      .i_and_sel     (oc_pin_combine_r[hbc_pkg::OC_DRIVER_OFF_COMBINE_SELECT_BIT]),
      .i_rst_val     (1'b0),
      .o_level       (driver_off_lvl)
   );

   hbc_pin_combine u_bridge_cmd (
      .i_ref_clk     (i_ref_clk),
      .i_rst_n       (i_rst_n),
      .i_pin         (i_bridge_command_pin),
      .i_soft        (i_soft_bridge_command),
      .i_override_en (override_en),
      .i_and_sel     (oc_pin_combine_r[hbc_pkg::OC_BRIDGE_SEL_BIT]),
      .i_rst_val     (1'b0),
      .o_level       (bridge_cmd_lvl)
   );

   assign o_driver_off     = driver_off_lvl;
   assign o_bridge_command = bridge_cmd_lvl;

endmodule : hbc_config_regs

/* File: tb/hbc_host_model.sv */
/*
 * host side of the decoded byte port: one strobe per access.
 * assumes the bench calls access() and owns every other input.
 */
module hbc_host_model (
   input  wire logic i_ref_clk,
   output logic       o_wr_en,
   output logic       o_rd_en,
   output logic [7:0] o_addr,
   output logic [7:0] o_wr_data
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 8'h00;
      o_wr_data = 8'h00;
   end

   // released address and data lines show the inverse and the strobes drop to zero, so stale values cannot pass
   task automatic access(input logic wr, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge i_ref_clk);
      o_wr_en <= wr;
      o_rd_en <= !wr;
      o_addr <= a;
      o_wr_data <= d;
      @(posedge i_ref_clk);
      o_wr_en <= 1'b0;
      o_rd_en <= 1'b0;
      o_addr <= ~a;
      o_wr_data <= ~d;
   endtask : access
endmodule : hbc_host_model

/* File: tb/hbc_config_regs_chk.sv */
/*
 * checker on the ports of the configuration register bank.
 * assumes one clock domain and the bank's active low reset.
 */
module hbc_config_regs_chk #(
   parameter int OFF_TIME_0_CYCLES = 20,
   parameter int OFF_TIME_1_CYCLES = 30,
   parameter int OFF_TIME_2_CYCLES = 40,
   parameter int OFF_TIME_3_CYCLES = 50
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [1:0] i_cfg_lock_code,
   input wire logic [1:0] i_pin_lock_code,
   input wire logic i_soft_bridge_command,
   input wire logic i_soft_driver_off,
   input wire logic i_bridge_command_pin,
   input wire logic i_driver_off_pin,
   input wire logic [7:0] o_rd_data,
   input wire logic o_rd_valid,
   input wire logic o_rd_hit,
   input wire logic o_wr_refused,
   input wire hbc_pkg::hbc_cfg_t o_cfg,
   input wire logic [13:0] o_off_time_cycles,
   input wire logic [10:0] o_oc_filter_cycles,
   input wire logic [6:0] o_oc_threshold_pct,
   input wire logic o_bridge_command,
   input wire logic o_driver_off
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   logic map_w;
   logic refuse_w;
   assign map_w = (i_addr >= 8'h0b) && (i_addr <= 8'h0d);
   assign refuse_w = i_wr_en && map_w && (i_cfg_lock_code == 2'b10);

   function automatic logic [13:0] off_of(input logic [1:0] c);
      case (c)
         2'b00: off_of = 14'(OFF_TIME_0_CYCLES);
         2'b01: off_of = 14'(OFF_TIME_1_CYCLES);
         2'b10: off_of = 14'(OFF_TIME_2_CYCLES);
         default: off_of = 14'(OFF_TIME_3_CYCLES);
      endcase
   endfunction : off_of

   function automatic logic [10:0] filt_of(input logic [1:0] c);
      case (c)
         2'b00: filt_of = 11'h5dc;
         2'b01: filt_of = 11'h2ee;
         2'b10: filt_of = 11'h177;
         default: filt_of = 11'h032;
      endcase
   endfunction : filt_of

   chk_rd_valid_pulse: assert property (i_rd_en |=> o_rd_valid)
      else $error("read not answered");
   chk_rd_no_spurious: assert property (!i_rd_en |=> !o_rd_valid)
      else $error("read answer without request");
   chk_rd_hit_map: assert property (i_rd_en |=> o_rd_hit == $past(map_w))
      else $error("hit flag wrong");
   chk_unmapped_zero: assert property (i_rd_en && !map_w |=> o_rd_data == 8'h00)
      else $error("unmapped read not zero");
   chk_reserved_zero: assert property (i_rd_en && map_w |=>
      ($past(i_addr) == 8'h0b) ? (o_rd_data[4:3] == 2'b00) : !o_rd_data[5])
      else $error("reserved bit read as one");
   chk_lock_refuses: assert property (refuse_w |=> o_wr_refused)
      else $error("locked write not refused");
   chk_refuse_cause: assert property (o_wr_refused |-> $past(refuse_w))
      else $error("refusal without locked write");
   chk_pin_locked: assert property (i_pin_lock_code != 2'b10 |=>
      o_bridge_command == $past(i_bridge_command_pin) &&
      o_driver_off == $past(i_driver_off_pin))
      else $error("locked pin not passed through");
   chk_pin_combined: assert property (i_pin_lock_code == 2'b10 &&
      $past(i_rst_n) |=> o_driver_off == (o_cfg.driver_off_combine_select ?
      ($past(i_driver_off_pin) && $past(i_soft_driver_off)) :
      ($past(i_driver_off_pin) || $past(i_soft_driver_off))))
      else $error("driver off combine wrong");
   chk_decode_tables: assert property ($past(i_rst_n) |->
      o_off_time_cycles == off_of(o_cfg.regulation_off_time) &&
      o_oc_filter_cycles == filt_of(o_cfg.overcurrent_filter_select))
      else $error("decoded time wrong");

   cov_refused: cover property (refuse_w ##1 o_wr_refused);
   cov_read_hit: cover property (i_rd_en && map_w ##1 o_rd_hit);
   cov_and_combine: cover property (i_pin_lock_code == 2'b10 &&
      o_cfg.bridge_combine_select);
endmodule : hbc_config_regs_chk

bind hbc_config_regs hbc_config_regs_chk #(
   .OFF_TIME_0_CYCLES(OFF_TIME_0_CYCLES),
   .OFF_TIME_1_CYCLES(OFF_TIME_1_CYCLES),
   .OFF_TIME_2_CYCLES(OFF_TIME_2_CYCLES),
   .OFF_TIME_3_CYCLES(OFF_TIME_3_CYCLES)
) u_chk (.*);

/* File: tb/half_bridge_config_registers_test.sv */
/*
 * self-checking bench for the configuration register bank.
 * assumes the host model drives the byte port; pins come from here.
 */
module half_bridge_config_registers_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OT [4] = '{20, 30, 40, 50};
   logic i_ref_clk, i_rst_n, wr_en, rd_en, s_br, s_do, p_br, p_do;
   logic [7:0] addr, wr_data, rd_data, r8;
   logic [1:0] cfg_lock, pin_lock;
   logic rd_valid, rd_hit, wr_refused, br_out, do_out;
   hbc_pkg::hbc_cfg_t cfg;
   logic [13:0] off_cyc;
   logic [10:0] filt_cyc;
   logic [6:0] thr_pct;
   logic [31:0] r;
   logic [7:0] mdl [3];
   logic [7:0] msk [3] = '{8'he7, 8'hdf, 8'hdf};
   int error_cnt, check_count, seed;

   hbc_host_model host (.i_ref_clk(i_ref_clk), .o_wr_en(wr_en),
      .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));
   hbc_config_regs #(.OFF_TIME_0_CYCLES(OT[0]), .OFF_TIME_1_CYCLES(OT[1]),
      .OFF_TIME_2_CYCLES(OT[2]), .OFF_TIME_3_CYCLES(OT[3])) uut (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data),
      .i_cfg_lock_code(cfg_lock), .i_pin_lock_code(pin_lock),
      .i_soft_bridge_command(s_br), .i_soft_driver_off(s_do),
      .i_bridge_command_pin(p_br), .i_driver_off_pin(p_do),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_rd_hit(rd_hit),
      .o_wr_refused(wr_refused), .o_cfg(cfg), .o_off_time_cycles(off_cyc),
      .o_oc_filter_cycles(filt_cyc), .o_oc_threshold_pct(thr_pct),
      .o_bridge_command(br_out), .o_driver_off(do_out));

   initial
   begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input logic [15:0] seen, exp, input string m);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s %h not %h", $time, m, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("mismatches %0d of %0d checks", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   task automatic rd_chk(input logic [7:0] a);
      int n;
      logic hit;
      n = 0;
      hit = a >= 8'h0b && a <= 8'h0d;
      host.access(1'b0, a, 8'h00);
      #1;
      while (rd_valid !== 1'b1 && n < 4)
      begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      if (rd_valid !== 1'b1)
      begin
         error_cnt++;
         complete_run();
      end
      check(rd_data, hit ? mdl[a - 8'h0b] : 8'h00, "read");
      check(rd_hit, hit, "hit");
   endtask : rd_chk

   // mapped writes land only while the config lock is open
   task automatic wr_mdl(input logic [7:0] a, input logic [7:0] d);
      logic hit;
      hit = a >= 8'h0b && a <= 8'h0d;
      host.access(1'b1, a, d);
      if (hit && cfg_lock != 2'b10)
         mdl[a - 8'h0b] = d & msk[a - 8'h0b];
      #1;
      check(wr_refused, hit && cfg_lock == 2'b10, "refusal");
   endtask : wr_mdl

   task automatic chk_fields();
      hbc_pkg::hbc_cfg_t e;
      logic [1:0] t;
      int ft [4];
      ft = '{1500, 750, 375, 50};
      repeat (2) @(posedge i_ref_clk);
      #1;
      t = mdl[2][4:3];
      e = '{mdl[0][6:5], mdl[0][2:0], mdl[1][7:6], mdl[1][4:2],
            mdl[2][7:6], t, mdl[2][2], mdl[2][0]};
      check(cfg, e, "fields");
      check(off_cyc, 16'(OT[mdl[1][7:6]]), "off time");
      check(filt_cyc, 16'(ft[mdl[2][7:6]]), "filter");
      check(thr_pct, t == 2'b00 ? 16'd100 : t == 2'b10 ? 16'd75 : 16'd50,
            "threshold");
   endtask : chk_fields

   initial
   begin
      seed = 32'h6598;
      error_cnt = 0;
      check_count = 0;
      {i_rst_n, cfg_lock, pin_lock, s_br, s_do, p_br, p_do} = '0;
      mdl = '{8'h00, 8'h40, 8'h04};
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      for (int a = 10; a < 15; a++)
         rd_chk(8'(a));
      chk_fields();
      for (int k = 0; k < 40; k++)
      begin
         r = $random(seed);
         r8 = 8'h0b + 8'(r[9:8]);
         @(posedge i_ref_clk);
         cfg_lock <= r[13:12];
         if (r[14])
            wr_mdl(r8, r[7:0]);
         else
            rd_chk(r8);
      end
      @(posedge i_ref_clk);
      cfg_lock <= 2'b00;
      for (int c = 0; c < 4; c++)
      begin
         wr_mdl(8'h0c, {c[1:0], 6'h1f});
         wr_mdl(8'h0d, {c[1:0], 1'b1, c[1:0], 3'h5});
         chk_fields();
      end
      for (int lk = 0; lk < 4; lk++)
         for (int sl = 0; sl < 2; sl++)
         begin
            @(posedge i_ref_clk);
            pin_lock <= lk[1:0];
            wr_mdl(8'h0d, {mdl[2][7:3], sl[0], mdl[2][1], sl[0]});
            for (int pv = 0; pv < 4; pv++)
            begin
               @(posedge i_ref_clk);
               {p_br, s_br, p_do, s_do} <= {pv[1:0], pv[0], pv[1]};
               @(posedge i_ref_clk);
               #1;
               check(br_out, lk != 2 ? pv[1] : sl[0] ? pv[0] & pv[1]
                     : pv[0] | pv[1], "bridge");
               check(do_out, lk != 2 ? pv[0] : sl[0] ? pv[0] & pv[1]
                     : pv[0] | pv[1], "driver off");
            end
         end
      complete_run();
   end
endmodule : half_bridge_config_registers_test
